// [trc_core_model.sv]
// core trace port model issuing branch traffic
`timescale 1ns/1ps
module trc_core_model
(
    input wire logic clk_i,
    output logic lockup_o,
    output logic seq_o,
    output logic load_o,
    output logic [30:0] addr_o,
    output logic atomic_o
);
    initial
    begin
        lockup_o = 1'b0;
        seq_o = 1'b1;
        load_o = 1'b0;
        addr_o = 31'h0;
        atomic_o = 1'b0;
    end
    // address register holds after the load, as in the core
    task automatic branch(input logic [31:0] pc, input logic at);
        load_o <= 1'b1;
        seq_o <= 1'b0;
        addr_o <= pc[31:1];
        atomic_o <= at;
        @(posedge clk_i);
        load_o <= 1'b0;
        seq_o <= 1'b1;
        atomic_o <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask : branch
    task automatic lock(input logic v);
        lockup_o <= v;
        @(posedge clk_i);
    endtask : lock
endmodule : trc_core_model

// [trc_pkg.sv]
// trace RAM controller shared constants and helpers
package trc_pkg;
    localparam logic [7:0] TRC_OFF_POSITION = 8'h00;
    localparam logic [7:0] TRC_OFF_CONTROL = 8'h04;
    localparam logic [7:0] TRC_OFF_LIMIT = 8'h08;
    localparam logic [7:0] TRC_OFF_BASE = 8'h0C;
    localparam logic [7:0] TRC_OFF_WP_ADDR = 8'h10;
    localparam logic [7:0] TRC_OFF_WP_DATA = 8'h14;
    localparam logic [7:0] TRC_OFF_WP_CFG = 8'h18;
    localparam logic [7:0] TRC_WP_STRIDE = 8'h10;
    localparam int TRC_PTR_LSB = 3;
    localparam int TRC_WRAP_BIT = 2;
    localparam int TRC_CTL_REC = 0;
    localparam int TRC_CTL_HALTEN = 1;
    localparam int TRC_CTL_HALT = 2;
    localparam int TRC_CFG_EN = 0;
    localparam int TRC_CFG_DATA = 1;
    localparam int TRC_CFG_BEGIN = 2;
    localparam int TRC_CFG_END = 3;
    localparam int TRC_CFG_W = 4;
    localparam logic [27:0] TRC_EXC_RET_HI = 28'hFFFFFFF;
    localparam logic [1:0] TRC_RESP_OKAY = 2'h0;
    localparam logic [1:0] TRC_RESP_SLVERR = 2'h2;
    localparam int TRC_HTRANS_ACT = 1;

    function automatic logic [31:0] trc_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++)
        begin
            if (be[b])
                r[8*b +: 8] = new_v[8*b +: 8];
        end
        return r;
    endfunction : trc_merge
endpackage : trc_pkg

// [trc_ram_controller.sv]
// system RAM controller with program trace packet recording
`timescale 1ns/1ps
module trc_ram_controller
    import trc_pkg::*;
#(
    parameter int RAM_WORDS = 512,
    parameter int NUM_CMP = 2
)
(
    input wire logic clk_i,
    input wire logic resetn_i,
    // ahb slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [31:0] hrdata_o,
    // core trace port
    input wire logic lockup_i,
    input wire logic next_addr_sequential_i,
    input wire logic exec_addr_load_i,
    input wire logic [30:0] exec_addr_half_i,
    input wire logic atomic_i,
    output logic halt_request_o,
    // observed core bus for watchpoints
    input wire logic bus_mon_valid_i,
    input wire logic [31:0] bus_mon_addr_i,
    input wire logic [31:0] bus_mon_data_i,
    // axi4-lite register port
    input wire logic [7:0] axi_awaddr_i,
    input wire logic axi_awvalid_i,
    output logic axi_awready_o,
    input wire logic [31:0] axi_wdata_i,
    input wire logic [3:0] axi_wstrb_i,
    input wire logic axi_wvalid_i,
    output logic axi_wready_o,
    output logic [1:0] axi_bresp_o,
    output logic axi_bvalid_o,
    input wire logic axi_bready_i,
    input wire logic [7:0] axi_araddr_i,
    input wire logic axi_arvalid_i,
    output logic axi_arready_o,
    output logic [31:0] axi_rdata_o,
    output logic [1:0] axi_rresp_o,
    output logic axi_rvalid_o,
    input wire logic axi_rready_i
);
    localparam int RAM_AW = $clog2(RAM_WORDS);
    localparam int PW = RAM_AW - 1;

    if (RAM_WORDS < 4 || RAM_WORDS != (1 << RAM_AW) || RAM_AW > 30 || NUM_CMP != 2)
    begin : g_bad
        $error("RAM_WORDS must be a power of two from 4 to 2^30 and NUM_CMP must be 2");
    end

    typedef struct packed {
        logic ap_valid;
        logic ap_write;
        logic [RAM_AW-1:0] ap_idx;
        logic [3:0] ap_be;
        logic [31:0] rdata;
        logic pkt_pend;
        logic [31:0] pkt_src;
        logic [31:0] pkt_dst;
        logic [30:0] cur_addr;
        logic exc_ret;
        logic first;
        logic rec;
        logic wrapped;
        logic halt;
        logic en_halt;
        logic [PW-1:0] ptr;
        logic [PW-1:0] base;
        logic [PW-1:0] limit;
        logic aw_got;
        logic [7:0] aw_addr;
        logic w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] axi_rdata;
        logic [1:0] rresp;
        logic [NUM_CMP-1:0][31:0] wp_addr;
        logic [NUM_CMP-1:0][31:0] wp_data;
        logic [NUM_CMP-1:0][TRC_CFG_W-1:0] wp_cfg;
    } trc_state_t;

    logic [1:0] rst_sync_ff;
    logic rst_n;
    trc_state_t st, nxt;
    logic [31:0] ram [RAM_WORDS];
    logic record_begin, record_end;
    logic branch, is_exc, origin, trace_we, ahb_we, accept;
    logic aw_take, w_take, aw_have, w_have, do_wr, wr_pos, wr_ctl;
    logic [7:0] waddr;
    logic [31:0] wdat, wmerged;
    logic [3:0] wstb;
    logic [32:0] wr_cur, rd_cur;
    logic [RAM_AW-1:0] h_idx;

    // reset released through two flops, asserted at once
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            rst_sync_ff <= 2'b00;
        else
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
    assign rst_n = rst_sync_ff[1];

    trc_watchpoint_unit #(
        .NUM_CMP(NUM_CMP)
    ) u_wp (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .mon_valid_i(bus_mon_valid_i),
        .mon_addr_i(bus_mon_addr_i),
        .mon_data_i(bus_mon_data_i),
        .cmp_addr_i(st.wp_addr),
        .cmp_data_i(st.wp_data),
        .cmp_cfg_i(st.wp_cfg),
        .record_begin_o(record_begin),
        .record_end_o(record_end)
    );

    function automatic logic [3:0] be_of(input logic [2:0] sz, input logic [1:0] lo);
        if (sz == 3'h0)
            return 4'h1 << lo;
        else if (sz == 3'h1)
            return lo[1] ? 4'hC : 4'h3;
        else
            return 4'hF;
    endfunction : be_of

    // returns {ok, value}
    function automatic logic [32:0] reg_rd(input trc_state_t s, input logic [7:0] a);
        logic [32:0] r;
        r = {1'b1, 32'h0};
        if (a == TRC_OFF_POSITION)
        begin
            r[TRC_PTR_LSB +: PW] = s.ptr;
            r[TRC_WRAP_BIT] = s.wrapped;
        end
        else if (a == TRC_OFF_CONTROL)
            r[2:0] = {s.halt, s.en_halt, s.rec};
        else if (a == TRC_OFF_LIMIT)
            r[TRC_PTR_LSB +: PW] = s.limit;
        else if (a == TRC_OFF_BASE)
            r[TRC_PTR_LSB +: PW] = s.base;
        else if (a == TRC_OFF_WP_ADDR)
            r[31:0] = s.wp_addr[0];
        else if (a == TRC_OFF_WP_DATA)
            r[31:0] = s.wp_data[0];
        else if (a == TRC_OFF_WP_CFG)
            r[TRC_CFG_W-1:0] = s.wp_cfg[0];
        else if (a == TRC_OFF_WP_ADDR + TRC_WP_STRIDE)
            r[31:0] = s.wp_addr[1];
        else if (a == TRC_OFF_WP_DATA + TRC_WP_STRIDE)
            r[31:0] = s.wp_data[1];
        else if (a == TRC_OFF_WP_CFG + TRC_WP_STRIDE)
            r[TRC_CFG_W-1:0] = s.wp_cfg[1];
        else
            r[32] = 1'b0;
        return r;
    endfunction : reg_rd

    // ahb: a pending packet write owns the array for one cycle
    assign accept = hsel_i && htrans_i[TRC_HTRANS_ACT] && hready_i;
    assign h_idx = haddr_i[RAM_AW+1:2];
    assign trace_we = st.pkt_pend;
    assign ahb_we = st.ap_valid && st.ap_write && !st.pkt_pend;
    assign hreadyout_o = !(st.ap_valid && st.ap_write && st.pkt_pend);
    assign hresp_o = 1'b0;
    assign hrdata_o = st.rdata;

    // trace detection
    assign branch = exec_addr_load_i && !next_addr_sequential_i && st.rec && !lockup_i;
    assign is_exc = exec_addr_half_i[30:3] == TRC_EXC_RET_HI;
    // return code target forces origin 0, the packet after it forces 1
    assign origin = st.exc_ret ? 1'b1 : (is_exc ? 1'b0 : atomic_i);

    // axi handshake terms
    assign axi_awready_o = !st.aw_got && !st.bvalid;
    assign axi_wready_o = !st.w_got && !st.bvalid;
    assign axi_arready_o = !st.rvalid;
    assign aw_take = axi_awvalid_i && axi_awready_o;
    assign w_take = axi_wvalid_i && axi_wready_o;
    assign aw_have = st.aw_got || aw_take;
    assign w_have = st.w_got || w_take;
    assign do_wr = aw_have && w_have && !st.bvalid;
    assign waddr = st.aw_got ? st.aw_addr : axi_awaddr_i;
    assign wdat = st.w_got ? st.w_data : axi_wdata_i;
    assign wstb = st.w_got ? st.w_strb : axi_wstrb_i;
    assign wr_cur = reg_rd(st, waddr);
    assign rd_cur = reg_rd(st, axi_araddr_i);
    assign wmerged = trc_merge(wr_cur[31:0], wdat, wstb);
    assign wr_pos = do_wr && waddr == TRC_OFF_POSITION;
    assign wr_ctl = do_wr && waddr == TRC_OFF_CONTROL;

    always_comb
    begin
        nxt = st;
        // ahb address and data phases
        if (hready_i)
        begin
            nxt.ap_valid = accept;
            nxt.ap_write = hwrite_i;
            nxt.ap_idx = h_idx;
            nxt.ap_be = be_of(hsize_i, haddr_i[1:0]);
            if (accept && !hwrite_i)
            begin
                // forward a write completing this cycle to the same word
                nxt.rdata = ram[h_idx];
                if (ahb_we && st.ap_idx == h_idx)
                    nxt.rdata = trc_merge(ram[h_idx], hwdata_i, st.ap_be);
            end
        end
        // trace packet capture and pointer advance
        nxt.pkt_pend = branch;
        if (exec_addr_load_i)
            nxt.cur_addr = exec_addr_half_i;
        if (branch)
        begin
            nxt.pkt_src = {st.cur_addr, origin};
            nxt.pkt_dst = {exec_addr_half_i, st.first};
            nxt.exc_ret = is_exc;
            nxt.first = 1'b0;
        end
        if (st.pkt_pend)
        begin
            if (st.ptr == st.limit)
            begin
                nxt.ptr = st.base;
                nxt.wrapped = 1'b1;
            end
            else
                nxt.ptr = st.ptr + 1'b1;
        end
        // axi write: software wins on the pointer, hardware sets win elsewhere
        if (aw_take && !do_wr)
        begin
            nxt.aw_got = 1'b1;
            nxt.aw_addr = axi_awaddr_i;
        end
        if (w_take && !do_wr)
        begin
            nxt.w_got = 1'b1;
            nxt.w_data = axi_wdata_i;
            nxt.w_strb = axi_wstrb_i;
        end
        if (do_wr)
        begin
            nxt.aw_got = 1'b0;
            nxt.w_got = 1'b0;
            nxt.bvalid = 1'b1;
            nxt.bresp = wr_cur[32] ? TRC_RESP_OKAY : TRC_RESP_SLVERR;
            if (wr_pos)
            begin
                nxt.ptr = wmerged[TRC_PTR_LSB +: PW];
                nxt.wrapped = wmerged[TRC_WRAP_BIT];
            end
            else if (wr_ctl)
            begin
                nxt.rec = wmerged[TRC_CTL_REC];
                nxt.en_halt = wmerged[TRC_CTL_HALTEN];
                if (wmerged[TRC_CTL_HALT])
                    nxt.halt = 1'b0;
            end
            else if (waddr == TRC_OFF_LIMIT)
                nxt.limit = wmerged[TRC_PTR_LSB +: PW];
            else if (waddr == TRC_OFF_BASE)
                nxt.base = wmerged[TRC_PTR_LSB +: PW];
            else
            begin
                for (int i = 0; i < NUM_CMP; i++)
                begin
                    if (waddr == TRC_OFF_WP_ADDR + 8'(i * TRC_WP_STRIDE))
                        nxt.wp_addr[i] = wmerged;
                    else if (waddr == TRC_OFF_WP_DATA + 8'(i * TRC_WP_STRIDE))
                        nxt.wp_data[i] = wmerged;
                    else if (waddr == TRC_OFF_WP_CFG + 8'(i * TRC_WP_STRIDE))
                        nxt.wp_cfg[i] = wmerged[TRC_CFG_W-1:0];
                end
            end
        end
        else if (st.bvalid && axi_bready_i)
            nxt.bvalid = 1'b0;
        if (axi_arvalid_i && axi_arready_o)
        begin
            nxt.rvalid = 1'b1;
            nxt.axi_rdata = rd_cur[31:0];
            nxt.rresp = rd_cur[32] ? TRC_RESP_OKAY : TRC_RESP_SLVERR;
        end
        else if (st.rvalid && axi_rready_i)
            nxt.rvalid = 1'b0;
        // recording state: begin beats end, full buffer may halt the core
        if (record_end)
            nxt.rec = 1'b0;
        if (record_begin)
            nxt.rec = 1'b1;
        if (st.pkt_pend && st.ptr == st.limit && st.en_halt)
        begin
            nxt.halt = 1'b1;
            nxt.rec = 1'b0;
        end
        if (!st.rec && nxt.rec)
            nxt.first = 1'b1;
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st <= '0;
            st.limit <= '1;
        end
        else
            st <= nxt;
    end

    // array has no reset; both packet words land in one cycle
    always_ff @(posedge clk_i)
    begin
        if (trace_we)
        begin
            ram[{st.ptr, 1'b0}] <= st.pkt_src;
            ram[{st.ptr, 1'b1}] <= st.pkt_dst;
        end
        else if (ahb_we)
            ram[st.ap_idx] <= trc_merge(ram[st.ap_idx], hwdata_i, st.ap_be);
    end

    assign halt_request_o = st.halt;
    assign axi_bvalid_o = st.bvalid;
    assign axi_bresp_o = st.bresp;
    assign axi_rvalid_o = st.rvalid;
    assign axi_rdata_o = st.axi_rdata;
    assign axi_rresp_o = st.rresp;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n);

    sequence s_branch;
        exec_addr_load_i && !next_addr_sequential_i && st.rec && !lockup_i;
    endsequence
    chk_pkt_capture: assert property (s_branch |=> st.pkt_pend && st.pkt_src[31:1] == $past(st.cur_addr) &&
        st.pkt_dst[31:1] == $past(exec_addr_half_i))
        else $error("branch did not produce a packet");
    chk_pkt_words: assert property (st.pkt_pend |=> ram[{$past(st.ptr), 1'b0}] == $past(st.pkt_src) &&
        ram[{$past(st.ptr), 1'b1}] == $past(st.pkt_dst))
        else $error("packet words not stored at even and odd word");
    chk_exception_return_code: assert property ((s_branch and st.exc_ret) |=> st.pkt_src[0])
        else $error("packet after return code lacks origin flag");
    chk_exc_first: assert property ((s_branch and is_exc && !st.exc_ret) |=> !st.pkt_src[0])
        else $error("return code packet has origin flag set");
    chk_start_flag: assert property (s_branch ##1 st.pkt_pend |-> !st.first)
        else $error("start flag left set after a packet");
    chk_ptr_step: assert property ((st.pkt_pend && st.ptr != st.limit && !wr_pos) |=>
        st.ptr == $past(st.ptr) + 1'b1)
        else $error("pointer did not advance by one packet");
    chk_zero_wait: assert property (!st.pkt_pend |-> hreadyout_o)
        else $error("wait state without packet write");
    chk_hold_phase: assert property ((!hreadyout_o && st.ap_valid) |=> st.ap_valid && $stable(st.ap_idx))
        else $error("pending address phase lost while stalled");
    chk_halt_full: assert property ((st.pkt_pend && st.ptr == st.limit && st.en_halt && !wr_ctl) |=>
        halt_request_o && !st.rec)
        else $error("full buffer did not halt recording");
endmodule : trc_ram_controller

// [trc_ram_controller_tb.sv]
// self-checking bench for the trace RAM controller
`timescale 1ns/1ps
module trc_ram_controller_tb
    import trc_pkg::*;
;
    logic clk, rstn, hsel, hwrite, hrdy, hresp, halt;
    logic [31:0] haddr, hwdata, hrdata, wdata, rdata;
    logic [1:0] htrans, bresp, rresp;
    logic [2:0] hsize;
    logic lk, sq, ld, at;
    logic [30:0] ia;
    logic [7:0] awaddr, araddr;
    logic awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
    logic [31:0] r;
    logic [1:0] rs;
    logic mv;
    logic [31:0] ma, md;
    logic [3:0] ws;
    int exp_w = 0;
    int n_fail = 0;
    int comparisons = 0;
    logic [31:0] pcs [0:7] = '{32'h100, 32'h2A4, 32'h3C8, 32'hFFFFFFF9, 32'h51E, 32'h600, 32'h70A, 32'h8F0};
    logic [0:4] ats = 5'b00100;
    logic [0:4] org = 5'b00101; // origin bits expected per packet
    logic [0:4] stf = 5'b01000;

    trc_core_model core (.clk_i(clk), .lockup_o(lk), .seq_o(sq), .load_o(ld), .addr_o(ia), .atomic_o(at));
    trc_ram_controller #(.RAM_WORDS(512), .NUM_CMP(2)) dut (.clk_i(clk), .resetn_i(rstn), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
        .hready_i(hrdy), .hreadyout_o(hrdy), .hresp_o(hresp), .hrdata_o(hrdata), .lockup_i(lk),
        .next_addr_sequential_i(sq), .exec_addr_load_i(ld), .exec_addr_half_i(ia), .atomic_i(at),
        .halt_request_o(halt), .bus_mon_valid_i(mv), .bus_mon_addr_i(ma), .bus_mon_data_i(md),
        .axi_awaddr_i(awaddr), .axi_awvalid_i(awv), .axi_awready_o(awr), .axi_wdata_i(wdata),
        .axi_wstrb_i(ws), .axi_wvalid_i(wv), .axi_wready_o(wr), .axi_bresp_o(bresp), .axi_bvalid_o(bv),
        .axi_bready_i(br), .axi_araddr_i(araddr), .axi_arvalid_i(arv), .axi_arready_o(arr),
        .axi_rdata_o(rdata), .axi_rresp_o(rresp), .axi_rvalid_o(rv), .axi_rready_i(rr));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic test_done();
        if (n_fail == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : test_done

    // one AHB transfer; the data phase must take exactly exp_w wait states
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [2:0] s);
        int waits;
        waits = 0;
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        hsize <= s;
        do @(posedge clk); while (hrdy !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hrdy !== 1'b1 && waits < 50)
        begin
            waits++;
            @(posedge clk);
        end
        r = hrdata;
        chk("ahb_waits", exp_w, waits);
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask : ahb

    // observed core access for one cycle, then let begin or end take effect
    task automatic mon(input logic [31:0] a, input logic [31:0] d);
        mv <= 1'b1;
        ma <= a;
        md <= d;
        @(posedge clk);
        mv <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : mon

    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        bit ad, wd;
        ad = 0;
        wd = 0;
        awaddr <= a;
        wdata <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        while (!(ad && wd))
        begin
            @(posedge clk);
            if (!ad && awr === 1'b1)
            begin
                ad = 1;
                awv <= 1'b0;
            end
            if (!wd && wr === 1'b1)
            begin
                wd = 1;
                wv <= 1'b0;
            end
        end
        do @(posedge clk); while (bv !== 1'b1);
        chk("bresp", e, bresp);
        br <= 1'b0;
        @(posedge clk);
    endtask : axw

    task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        araddr <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        do @(posedge clk); while (arr !== 1'b1);
        arv <= 1'b0;
        do @(posedge clk); while (rv !== 1'b1);
        chk("rresp", er, rresp);
        if (er === TRC_RESP_OKAY)
            chk("rdata", e, rdata);
        rr <= 1'b0;
        @(posedge clk);
    endtask : axr

    initial
    begin
        repeat (20000) @(posedge clk);
        n_fail++;
        test_done();
    end

    initial
    begin
        {hsel, hwrite, awv, wv, br, arv, rr} = '0;
        {haddr, hwdata, wdata} = '0;
        {htrans, hsize, awaddr, araddr} = '0;
        {mv, ma, md} = '0;
        ws = 4'hF;
        rstn = 1'b0;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        axr(TRC_OFF_POSITION, 32'h0, TRC_RESP_OKAY);
        axr(TRC_OFF_CONTROL, 32'h0, TRC_RESP_OKAY);
        axr(TRC_OFF_LIMIT, 32'h7F8, TRC_RESP_OKAY);
        axr(8'h30, 32'h0, TRC_RESP_SLVERR);
        axw(8'h30, 32'h1, TRC_RESP_SLVERR);
        // bus side reads and writes, decoded by address alone
        ahb(1'b1, 32'h400, 32'h12345678, 3'h2);
        ahb(1'b1, 32'h401, 32'h0000AB00, 3'h0);
        ahb(1'b0, 32'hC00, 32'h0, 3'h2);
        chk("ram_wrap", 32'h1234AB78, r);
        core.branch(pcs[0], 1'b0);
        axw(TRC_OFF_CONTROL, 32'h1, TRC_RESP_OKAY);
        for (int i = 1; i < 5; i++)
            core.branch(pcs[i], ats[i]);
        core.lock(1'b1);
        core.branch(pcs[5], 1'b0);
        core.lock(1'b0);
        axr(TRC_OFF_POSITION, 32'h20, TRC_RESP_OKAY);
        // restart: start flag must mark the next packet again
        axw(TRC_OFF_CONTROL, 32'h0, TRC_RESP_OKAY);
        core.branch(pcs[5], 1'b0);
        axw(TRC_OFF_CONTROL, 32'h1, TRC_RESP_OKAY);
        core.branch(pcs[6], 1'b0);
        axw(TRC_OFF_LIMIT, 32'h28, TRC_RESP_OKAY);
        axw(TRC_OFF_BASE, 32'h10, TRC_RESP_OKAY);
        core.branch(pcs[7], 1'b0);
        axr(TRC_OFF_POSITION, 32'h14, TRC_RESP_OKAY);
        for (int i = 0; i < 4; i++)
        begin
            ahb(1'b0, 8 * i, 32'h0, 3'h2);
            chk("pkt_src", {pcs[i][31:1], org[i + 1]}, r);
            ahb(1'b0, 8 * i + 4, 32'h0, 3'h2);
            chk("pkt_dst", {pcs[i + 1][31:1], stf[i + 1]}, r);
        end
        ahb(1'b0, 32'h20, 32'h0, 3'h2);
        chk("pkt_src", {pcs[5][31:1], 1'b0}, r);
        ahb(1'b0, 32'h24, 32'h0, 3'h2);
        chk("pkt_dst", {pcs[6][31:1], 1'b1}, r);
        ahb(1'b0, 32'h2C, 32'h0, 3'h2);
        chk("pkt_dst", {pcs[7][31:1], 1'b0}, r);
        // write data phase colliding with a packet write waits one cycle
        exp_w = 1;
        fork
            core.branch(pcs[1], 1'b0);
            ahb(1'b1, 32'h600, 32'hCAFEF00D, 3'h2);
        join
        exp_w = 0;
        ahb(1'b0, 32'h600, 32'h0, 3'h2);
        chk("ram_stall", 32'hCAFEF00D, r);
        ahb(1'b0, 32'h14, 32'h0, 3'h2);
        chk("pkt_dst", {pcs[1][31:1], 1'b0}, r);
        // full buffer with halt enabled, pointer set through one byte lane
        ws <= 4'h1;
        axw(TRC_OFF_POSITION, 32'h28, TRC_RESP_OKAY);
        ws <= 4'hF;
        axw(TRC_OFF_CONTROL, 32'h3, TRC_RESP_OKAY);
        core.branch(pcs[2], 1'b0);
        chk("halt", 32'h1, {31'h0, halt});
        axr(TRC_OFF_CONTROL, 32'h6, TRC_RESP_OKAY);
        axr(TRC_OFF_POSITION, 32'h14, TRC_RESP_OKAY);
        axw(TRC_OFF_CONTROL, 32'h4, TRC_RESP_OKAY);
        chk("halt", 32'h0, {31'h0, halt});
        // comparator 0 begins on address, comparator 1 ends on address and data
        axw(TRC_OFF_WP_ADDR, 32'h700, TRC_RESP_OKAY);
        axw(TRC_OFF_WP_CFG, 32'h5, TRC_RESP_OKAY);
        axw(TRC_OFF_WP_ADDR + TRC_WP_STRIDE, 32'h800, TRC_RESP_OKAY);
        axw(TRC_OFF_WP_DATA + TRC_WP_STRIDE, 32'h55, TRC_RESP_OKAY);
        axw(TRC_OFF_WP_CFG + TRC_WP_STRIDE, 32'hB, TRC_RESP_OKAY);
        mon(32'h700, 32'h0);
        axr(TRC_OFF_CONTROL, 32'h1, TRC_RESP_OKAY);
        mon(32'h800, 32'h0);
        axr(TRC_OFF_CONTROL, 32'h1, TRC_RESP_OKAY);
        mon(32'h800, 32'h55);
        axr(TRC_OFF_CONTROL, 32'h0, TRC_RESP_OKAY);
        test_done();
    end
endmodule : trc_ram_controller_tb

// [trc_watchpoint_unit.sv]
// watchpoint comparators producing record begin and end pulses
`timescale 1ns/1ps
module trc_watchpoint_unit
    import trc_pkg::*;
#(
    parameter int NUM_CMP = 2
)
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic mon_valid_i,
    input wire logic [31:0] mon_addr_i,
    input wire logic [31:0] mon_data_i,
    input wire logic [NUM_CMP-1:0][31:0] cmp_addr_i,
    input wire logic [NUM_CMP-1:0][31:0] cmp_data_i,
    input wire logic [NUM_CMP-1:0][TRC_CFG_W-1:0] cmp_cfg_i,
    output logic record_begin_o,
    output logic record_end_o
);
    typedef struct packed {
        logic rec_begin;
        logic rec_end;
    } trc_wp_state_t;

    trc_wp_state_t st, nxt;
    logic [NUM_CMP-1:0] hit;

    if (NUM_CMP < 1)
    begin : g_bad
        $error("watchpoint unit needs at least one comparator");
    end

    for (genvar i = 0; i < NUM_CMP; i++)
    begin : g_cmp
        // data match is optional per comparator
        assign hit[i] = mon_valid_i && cmp_cfg_i[i][TRC_CFG_EN] && mon_addr_i == cmp_addr_i[i] &&
                        (!cmp_cfg_i[i][TRC_CFG_DATA] || mon_data_i == cmp_data_i[i]);
    end

    always_comb
    begin
        nxt = st;
        nxt.rec_begin = 1'b0;
        nxt.rec_end = 1'b0;
        for (int i = 0; i < NUM_CMP; i++)
        begin
            if (hit[i] && cmp_cfg_i[i][TRC_CFG_BEGIN])
                nxt.rec_begin = 1'b1;
            if (hit[i] && cmp_cfg_i[i][TRC_CFG_END])
                nxt.rec_end = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            st <= '0;
        else
            st <= nxt;
    end

    assign record_begin_o = st.rec_begin;
    assign record_end_o = st.rec_end;

    chk_wp_begin_pulse: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (hit[0] && cmp_cfg_i[0][TRC_CFG_BEGIN]) |=> record_begin_o)
        else $error("begin pulse missing after comparator hit");
endmodule : trc_watchpoint_unit
